// *** design/swra_serial_link.sv ***
// serial frame shifter running on the link clock
`timescale 1ns/10ps
`include "swra_params.svh"
module swra_serial_link
    import swra_pkg::*;
(
    input  wire logic       sclk_link,
    input  wire logic       resetn,
    input  wire logic       fs_n,
    input  wire logic       din,
    output logic            dout,
    output logic            dout_oe,
    output swra_word_s      rx_word,
    output logic            req_tgl,
    input  wire swra_word_s rsp_word,
    input  wire logic       ack_tgl
);

    logic       link_rstn;
    logic       ack_sync;
    swra_lnk_e  state_q;
    swra_lnk_e  state_d;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic [15:0] rx_q;
    logic [15:0] rx_d;
    logic [15:0] tx_q;
    logic [15:0] tx_d;
    swra_word_s hold_q;
    swra_word_s hold_d;
    logic       req_q;
    logic       req_d;
    logic       ack_seen_q;
    logic       ack_seen_d;

    // reset and answer toggle brought into the link clock
    swra_sync #(.WIDTH(2)) u_sync_lnk
    (
        .clk      (sclk_link),
        .async_in ({resetn, ack_tgl}),
        .sync_out ({link_rstn, ack_sync})
    );

    // frame shifter: 16 bits msb first while the frame runs
    always_comb
    begin
        state_d    = state_q;
        cnt_d      = cnt_q;
        rx_d       = rx_q;
        tx_d       = tx_q;
        hold_d     = hold_q;
        req_d      = req_q;
        ack_seen_d = ack_seen_q;
        case (state_q)
            SWRA_LNK_IDLE:
            begin
                if (!fs_n)
                begin
                    rx_d    = {rx_q[14:0], din};
                    tx_d    = {tx_q[14:0], 1'b0};
                    cnt_d   = 4'h1;
                    state_d = SWRA_LNK_SHIFT;
                end
                else if (ack_sync != ack_seen_q)
                begin
                    tx_d       = rsp_word;  // answer goes out next frame
                    ack_seen_d = ack_sync;
                end
            end
            SWRA_LNK_SHIFT:
            begin
                rx_d  = {rx_q[14:0], din};
                tx_d  = {tx_q[14:0], 1'b0};
                cnt_d = cnt_q + 4'h1;
                if (cnt_q == `SWRA_LAST_BIT)
                begin
                    hold_d  = {rx_q[14:0], din};
                    req_d   = ~req_q;
                    cnt_d   = 4'h0;
                    state_d = SWRA_LNK_IDLE;
                end
            end
            default:
            begin
                state_d = SWRA_LNK_IDLE;
            end
        endcase
        if (!link_rstn)
        begin
            state_d    = SWRA_LNK_IDLE;
            cnt_d      = 4'h0;
            rx_d       = `SWRA_WORD_RST;
            tx_d       = `SWRA_WORD_RST;
            hold_d     = `SWRA_WORD_RST;
            req_d      = 1'b0;
            ack_seen_d = 1'b0;
        end
    end

    always_ff @(posedge sclk_link)
    begin
        state_q    <= state_d;
        cnt_q      <= cnt_d;
        rx_q       <= rx_d;
        tx_q       <= tx_d;
        hold_q     <= hold_d;
        req_q      <= req_d;
        ack_seen_q <= ack_seen_d;
    end

    // pin drive and crossing outputs
    assign dout    = tx_q[15];
    assign dout_oe = ~fs_n | (state_q == SWRA_LNK_SHIFT);
    assign rx_word = hold_q;
    assign req_tgl = req_q;

endmodule

// *** design/swra_sync.sv ***
// two flip-flop level synchroniser
`timescale 1ns/10ps
module swra_sync
#(
    parameter int WIDTH = 1
)
(
    input  wire logic             clk,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    // first stage feeds only the second
    always_comb
    begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    always_ff @(posedge clk)
    begin
        meta_q <= meta_d;
        sync_q <= sync_d;
    end

    assign sync_out = sync_q;

endmodule

// *** design/swra_top.sv ***
// register bank decoding secondary serial words
//
// Function
// - bits D12 to D8 of a secondary word select the register
// - a write loads bits D7 to D0 into the addressed register
// - bit D13 chooses between a read and a write access
// - D13 low means write, D13 high means read
// - with D15 D14 zero: 0 no-op, 1 first, 2 second control
// - software reset bit fires once and clears itself
// - reading second control shows decimator overflow in D5
`timescale 1ns/10ps
`include "swra_params.svh"
module swra_top
    import swra_pkg::*;
(
    input  wire logic  clk_sys,
    input  wire logic  resetn,
    input  wire logic  sclk_link,
    input  wire logic  fs_n,
    input  wire logic  din,
    output logic       dout,
    output logic       dout_oe,
    input  wire logic  decim_ovf,
    input  wire logic  [1:0] flag_pins,
    output swra_ctrl1_s ctrl1_cfg,
    output logic       phone_mode,
    output logic       soft_reset,
    output logic       word_done
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    swra_word_s  lnk_word;
    logic        lnk_req_tgl;
    logic        req_sync;
    logic [1:0]  flag_sync;
    logic        req_seen_q;
    logic        req_seen_d;
    logic        req_edge;
    swra_sys_e   state_q;
    swra_sys_e   state_d;
    swra_word_s  word_q;
    swra_word_s  word_d;
    swra_word_s  rsp_q;
    swra_word_s  rsp_d;
    logic        ack_q;
    logic        ack_d;
    logic [7:0]  ctrl1_q;
    logic [7:0]  ctrl1_d;
    logic [7:0]  ctrl2_q;
    logic [7:0]  ctrl2_d;
    logic        swrst_q;
    logic        swrst_d;
    logic        ovf_q;
    logic        ovf_d;
    logic        done_q;
    logic        done_d;
    logic        is_read;
    logic        is_write;
    logic        hit_c1;
    logic        hit_c2;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------

    // a word is decoded only with its two upper bits clear
    function automatic logic word_ok(input swra_word_s w);
        word_ok = (w.upper == `SWRA_UPPER_OK);
    endfunction

    // register hit for a given number
    function automatic logic reg_hit(input swra_word_s w,
                                     input logic [4:0] num);
        reg_hit = word_ok(w) && (w.addr == num);
    endfunction

    // ----------------------------------------------------------------
    // link side and crossings
    // ----------------------------------------------------------------

    // link clock frame shifter
    swra_serial_link u_link
    (
        .sclk_link (sclk_link),
        .resetn    (resetn),
        .fs_n      (fs_n),
        .din       (din),
        .dout      (dout),
        .dout_oe   (dout_oe),
        .rx_word   (lnk_word),
        .req_tgl   (lnk_req_tgl),
        .rsp_word  (rsp_q),
        .ack_tgl   (ack_q)
    );

    // frame toggle and flag pins brought into the system clock
    swra_sync #(.WIDTH(3)) u_sync_sys
    (
        .clk      (clk_sys),
        .async_in ({lnk_req_tgl, flag_pins}),
        .sync_out ({req_sync, flag_sync})
    );

    // new frame when the synced toggle moves
    assign req_edge = (req_sync != req_seen_q);

    // ----------------------------------------------------------------
    // decode of the captured word
    // ----------------------------------------------------------------

    // access type and register selects
    always_comb
    begin
        is_read  = word_ok(word_q) && (word_q.rw != `SWRA_RW_WRITE);
        is_write = word_ok(word_q) && (word_q.rw == `SWRA_RW_WRITE);
        hit_c1   = reg_hit(word_q, `SWRA_REG_CTRL1);
        hit_c2   = reg_hit(word_q, `SWRA_REG_CTRL2);
    end

    // ----------------------------------------------------------------
    // transaction sequencer
    // ----------------------------------------------------------------

    // take word, execute, hand answer back to the link
    always_comb
    begin
        state_d    = state_q;
        word_d     = word_q;
        req_seen_d = req_seen_q;
        ack_d      = ack_q;
        done_d     = 1'b0;
        case (state_q)
            SWRA_SYS_IDLE:
            begin
                if (req_edge)
                begin
                    word_d     = lnk_word;  // stable while toggle moved
                    req_seen_d = req_sync;
                    state_d    = SWRA_SYS_EXEC;
                end
            end
            SWRA_SYS_EXEC:
            begin
                state_d = SWRA_SYS_ANSWER;
            end
            SWRA_SYS_ANSWER:
            begin
                ack_d   = ~ack_q;  // answer word already stable
                done_d  = 1'b1;
                state_d = SWRA_SYS_IDLE;
            end
            default:
            begin
                state_d = SWRA_SYS_IDLE;
            end
        endcase
        if (!resetn)
        begin
            state_d    = SWRA_SYS_IDLE;
            word_d     = `SWRA_WORD_RST;
            req_seen_d = 1'b0;
            ack_d      = 1'b0;
            done_d     = 1'b0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        state_q    <= state_d;
        word_q     <= word_d;
        req_seen_q <= req_seen_d;
        ack_q      <= ack_d;
        done_q     <= done_d;
    end

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------

    // register writes, self clearing reset bit, sticky overflow
    always_comb
    begin
        ctrl1_d = ctrl1_q;
        ctrl2_d = ctrl2_q;
        swrst_d = 1'b0;
        ovf_d   = ovf_q;
        if (state_q == SWRA_SYS_EXEC)
        begin
            if (is_read && hit_c2)
            begin
                ovf_d = 1'b0;
            end
            if (is_write && hit_c1)
            begin
                ctrl1_d = word_q.data;
                swrst_d = word_q.data[`SWRA_C1_SWRST];
            end
            if (is_write && hit_c2)
            begin
                ctrl2_d = word_q.data;
            end
        end
        if (swrst_q)
        begin
            ctrl1_d[`SWRA_C1_SWRST] = 1'b0;
        end
        if (decim_ovf)
        begin
            ovf_d = 1'b1;  // set wins over the read clear
        end
        if (!resetn)
        begin
            ctrl1_d = `SWRA_CTRL1_RST;
            ctrl2_d = `SWRA_CTRL2_RST;
            swrst_d = 1'b0;
            ovf_d   = 1'b0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        ctrl1_q <= ctrl1_d;
        ctrl2_q <= ctrl2_d;
        swrst_q <= swrst_d;
        ovf_q   <= ovf_d;
    end

    // ----------------------------------------------------------------
    // answer word
    // ----------------------------------------------------------------

    // echo header, low byte holds the read value or zero
    always_comb
    begin
        rsp_d = rsp_q;
        if (state_q == SWRA_SYS_EXEC)
        begin
            rsp_d      = word_q;
            rsp_d.data = 8'h00;
            if (is_read && hit_c1)
            begin
                rsp_d.data = ctrl1_q;
            end
            if (is_read && hit_c2)
            begin
                rsp_d.data                = 8'h00;
                rsp_d.data[`SWRA_C2_PHONE] = ctrl2_q[`SWRA_C2_PHONE];
                rsp_d.data[`SWRA_C2_OVF]   = ovf_q | decim_ovf;
                rsp_d.data[`SWRA_C2_FLAG1] = flag_sync[1];
                rsp_d.data[`SWRA_C2_FLAG0] = flag_sync[0];
            end
        end
        if (!resetn)
        begin
            rsp_d = `SWRA_WORD_RST;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        rsp_q <= rsp_d;
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------

    // control fields straight from the registers
    assign ctrl1_cfg  = ctrl1_q;
    assign phone_mode = ctrl2_q[`SWRA_C2_PHONE];
    assign soft_reset = swrst_q;
    assign word_done  = done_q;

endmodule

// *** inc/swra_params.svh ***
// constants for the secondary word register access block
`ifndef SWRA_PARAMS_SVH
`define SWRA_PARAMS_SVH

// ----------------------------------------------------------------
// register numbers carried in the address field
// ----------------------------------------------------------------
`define SWRA_REG_NOP     5'h00
`define SWRA_REG_CTRL1   5'h01
`define SWRA_REG_CTRL2   5'h02

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SWRA_CTRL1_RST   8'h00
`define SWRA_CTRL2_RST   8'h00
`define SWRA_WORD_RST    16'h0000

// ----------------------------------------------------------------
// field positions and codes
// ----------------------------------------------------------------
`define SWRA_C2_OVF      5
`define SWRA_C2_FLAG1    4
`define SWRA_C2_FLAG0    3
`define SWRA_C2_PHONE    2
`define SWRA_C1_SWRST    7
`define SWRA_RW_WRITE    1'h0
`define SWRA_UPPER_OK    2'h0
`define SWRA_WORD_BITS   16
`define SWRA_LAST_BIT    4'hF

`endif

// *** inc/swra_pkg.sv ***
// types shared by the secondary word register access block
package swra_pkg;

    // secondary serial word, msb first on the link
    typedef struct packed {
        logic [1:0] upper;
        logic       rw;
        logic [4:0] addr;
        logic [7:0] data;
    } swra_word_s;

    // first control register layout
    typedef struct packed {
        logic       swrst;
        logic       pwrdn;
        logic       aux_sel;
        logic       mon_aux;
        logic [1:0] mon_gain;
        logic       loopback;
        logic       mode16;
    } swra_ctrl1_s;

    // link side frame states
    typedef enum logic [1:0] {
        SWRA_LNK_IDLE  = 2'b01,
        SWRA_LNK_SHIFT = 2'b10
    } swra_lnk_e;

    // system side transaction states
    typedef enum logic [2:0] {
        SWRA_SYS_IDLE   = 3'b001,
        SWRA_SYS_EXEC   = 3'b010,
        SWRA_SYS_ANSWER = 3'b100
    } swra_sys_e;

endpackage

// *** sim/swra_host_model.sv ***
// host serial port model sending secondary words
`timescale 1ns/10ps
module swra_host_model
(
    input  wire logic sclk_link,
    input  wire logic dout,
    input  wire logic dout_oe,
    output logic      fs_n,
    output logic      din
);
    logic last_q = 1'b0;
    wire  dline  = dout_oe ? dout : ~last_q;  // released line drifts

    initial
    begin
        fs_n = 1'b1;
        din  = 1'b0;
    end

    // remember the last driven bit
    always @(posedge sclk_link)
        if (dout_oe)
            last_q <= dout;

    // one frame msb first, frame sync low for the first bit only, then gap idle clocks
    task automatic xfer(input logic [15:0] w, output logic [15:0] r, input int gap);
        logic [15:0] sh;
        sh = w;
        @(posedge sclk_link);
        fs_n <= 1'b0;
        din  <= sh[15];
        for (int i = 15; i >= 0; i--)
        begin
            @(negedge sclk_link);
            r[i] = dline;
            @(posedge sclk_link);
            sh = {sh[14:0], ~sh[15]};
            fs_n <= 1'b1;
            din  <= sh[15];
        end
        repeat (gap) @(posedge sclk_link);
    endtask
endmodule

// *** sim/swra_top_properties.sv ***
// assertions on the ports of the register access block
`timescale 1ns/10ps
module swra_props
    import swra_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        resetn,
    input wire logic        sclk_link,
    input wire logic        fs_n,
    input wire logic        dout_oe,
    input wire swra_ctrl1_s ctrl1_cfg,
    input wire logic        phone_mode,
    input wire logic        soft_reset,
    input wire logic        word_done
);
    // ------------------------------
    // system side
    // ------------------------------
    chk_swrst_match: assert property (@(posedge clk_sys) disable iff (!resetn)
        soft_reset == ctrl1_cfg.swrst) else $error("reset pulse differs from bit");
    chk_swrst_clear: assert property (@(posedge clk_sys) disable iff (!resetn)
        soft_reset |=> !soft_reset && !ctrl1_cfg.swrst) else $error("reset bit stuck");
    chk_swrst_done: assert property (@(posedge clk_sys) disable iff (!resetn)
        soft_reset |=> word_done) else $error("reset pulse without word done");
    chk_cfg_done: assert property (@(posedge clk_sys) disable iff (!resetn)
        $changed(ctrl1_cfg) && !$past(ctrl1_cfg.swrst) |=> word_done)
        else $error("first control changed without a word");
    chk_phone_done: assert property (@(posedge clk_sys) disable iff (!resetn)
        $changed(phone_mode) |=> word_done) else $error("phone mode changed without a word");
    chk_done_gap: assert property (@(posedge clk_sys) disable iff (!resetn)
        word_done |=> !word_done [*8]) else $error("word done too close");
    // ------------------------------
    // link side
    // ------------------------------
    chk_oe_frame: assert property (@(posedge sclk_link) disable iff (!resetn)
        $fell(fs_n) ##1 fs_n |-> ##15 (!fs_n || !dout_oe))
        else $error("data out still driven after sixteen bits");
    chk_oe_span: assert property (@(posedge sclk_link) disable iff (!resetn)
        $fell(fs_n) |-> dout_oe [*8]) else $error("data out released in frame");
    cov_swrst: cover property (@(posedge clk_sys) disable iff (!resetn) soft_reset);
    cov_phone: cover property (@(posedge clk_sys) disable iff (!resetn) $rose(phone_mode));
    cov_frame: cover property (@(posedge sclk_link) disable iff (!resetn) $fell(fs_n));
endmodule

bind swra_top swra_props u_props
(
    .clk_sys, .resetn, .sclk_link, .fs_n, .dout_oe,
    .ctrl1_cfg, .phone_mode, .soft_reset, .word_done
);

// *** sim/test_swra_top.sv ***
// self-checking bench for the register access block
`timescale 1ns/10ps
module test_swra_top
    import swra_pkg::*;
;
    logic        clk_sys;
    logic        sclk_link;
    logic        resetn;
    logic        decim_ovf;
    logic [1:0]  flag_pins;
    logic        fs_n;
    logic        din;
    logic        dout;
    logic        dout_oe;
    swra_ctrl1_s ctrl1_cfg;
    logic        phone_mode;
    logic        soft_reset;
    logic        word_done;
    int          n_mismatch = 0;
    int          n_tests = 0;
    int          n_swrst = 0;
    int          n_done = 0;
    int          s;
    logic [15:0] rsp;

    swra_top DUT
    (
        .clk_sys, .resetn, .sclk_link, .fs_n, .din, .dout, .dout_oe, .decim_ovf,
        .flag_pins, .ctrl1_cfg, .phone_mode, .soft_reset, .word_done
    );
    swra_host_model host
    (
        .sclk_link, .dout, .dout_oe, .fs_n, .din
    );

    // ------------------------------
    // clocks and pulse counters
    // ------------------------------
    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    initial
    begin
        sclk_link = 1'b0;
        #7;
        forever #24 sclk_link = ~sclk_link;
    end
    always @(posedge clk_sys)
    begin
        if (soft_reset === 1'b1)
            n_swrst <= n_swrst + 1;
        if (word_done === 1'b1)
            n_done <= n_done + 1;
    end

    // ------------------------------
    // compare and access helpers
    // ------------------------------
    task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_cnt(input int got, input int exp);
        cmp_word(16'(got), 16'(exp));
    endtask
    // send a word, then fetch its answer with a no-op frame
    task automatic access(input logic [15:0] w, input logic [15:0] exp);
        host.xfer(w, rsp, 24);
        host.xfer(16'h0000, rsp, 24);
        cmp_word(rsp, exp);
    endtask
    task automatic end_sim();
        if (n_mismatch == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ------------------------------
    // scenarios
    // ------------------------------
    task automatic t_reset();
        cmp_word({8'h00, ctrl1_cfg}, 16'h0000);
        access(16'h2100, 16'h2100);
        access(16'h2200, 16'h2200);
    endtask
    task automatic t_write();
        access(16'h0176, 16'h0100);
        cmp_word({8'h00, ctrl1_cfg}, 16'h0076);
        access(16'h2100, 16'h2176);
        cmp_word({8'h00, ctrl1_cfg}, 16'h0076);
    endtask
    task automatic t_swrst();
        s = n_swrst;
        access(16'h0185, 16'h0100);
        cmp_cnt(n_swrst - s, 1);
        cmp_word({8'h00, ctrl1_cfg}, 16'h0005);
        access(16'h2100, 16'h2105);
    endtask
    task automatic t_ctrl2();
        @(posedge clk_sys);
        flag_pins <= 2'b10;
        access(16'h02FF, 16'h0200);
        cmp_word({15'h0000, phone_mode}, 16'h0001);
        access(16'h2200, 16'h2214);
        @(posedge clk_sys);
        decim_ovf <= 1'b1;
        @(posedge clk_sys);
        decim_ovf <= 1'b0;
        flag_pins <= 2'b01;
        access(16'h2200, 16'h222C);
        access(16'h2200, 16'h220C);
    endtask
    task automatic t_ignore();
        access(16'h0000, 16'h0000);
        access(16'h03AA, 16'h0300);
        access(16'h23AA, 16'h2300);
        access(16'hC1FF, 16'hC100);
        access(16'h4255, 16'h4200);
        cmp_word({7'h00, phone_mode, ctrl1_cfg}, 16'h0105);
    endtask
    task automatic t_b2b();
        s = n_done;
        host.xfer(16'h0133, rsp, 0);
        host.xfer(16'h0200, rsp, 24);
        cmp_word({7'h00, phone_mode, ctrl1_cfg}, 16'h0033);
        cmp_cnt(n_done - s, 2);
    endtask

    // ------------------------------
    // main sequence and watchdog
    // ------------------------------
    initial
    begin
        resetn    = 1'b0;
        decim_ovf = 1'b0;
        flag_pins = 2'b00;
        repeat (20) @(posedge sclk_link);
        @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (8) @(posedge sclk_link);
        t_reset();
        t_write();
        t_swrst();
        t_ctrl2();
        t_ignore();
        t_b2b();
        end_sim();
    end
    initial
    begin
        #200000;
        n_mismatch++;
        end_sim();
    end
endmodule
